// ### io_expander_pkg.sv
// Shared constants and types for the port expander bus target and change alert.
// Assumes a 10 MHz system clock and a link clocked directly by the bus clock.
package io_expander_pkg;

	// Port and address layout.
	localparam int PORT_W = 8;
	localparam int SEL_W = 2;
	localparam int STRAP_W = 3;
	localparam logic [3:0] ADDR_FIXED = 4'h4;
	localparam int RW_BIT = 0;

	// Register selection codes carried in the low bits of the command byte.
	localparam logic [SEL_W-1:0] SEL_INPUT = 2'h0;
	localparam logic [SEL_W-1:0] SEL_OUTPUT = 2'h1;
	localparam logic [SEL_W-1:0] SEL_POLARITY = 2'h2;
	localparam logic [SEL_W-1:0] SEL_CONFIG = 2'h3;

	// Reset values of the software visible registers.
	localparam logic [PORT_W-1:0] RST_OUTPUT = 8'hff;
	localparam logic [PORT_W-1:0] RST_POLARITY = 8'h00;
	localparam logic [PORT_W-1:0] RST_CONFIG = 8'hff;

	// Bit counter positions within a byte.
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_SECOND = 3'h1;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_STEP = 3'h1;

	// Alert valid delay: a longest time, so the cycle count rounds down.
	localparam int MCLK_PERIOD_NS = 100;
	localparam int ALERT_VALID_DELAY_NS = 4000;
	localparam int ALERT_VALID_RAW = ALERT_VALID_DELAY_NS / MCLK_PERIOD_NS;
	localparam int ALERT_VALID_CYCLES = (ALERT_VALID_RAW < 1) ? 1 : ALERT_VALID_RAW;
	localparam int ALERT_CNT_W = 6;
	localparam logic [ALERT_CNT_W-1:0] ALERT_VALID_CNT = ALERT_CNT_W'(ALERT_VALID_CYCLES);
	localparam logic [ALERT_CNT_W-1:0] ALERT_CNT_STEP = 6'h01;

	// Phases of a bus transaction as seen on the link clock.
	typedef enum logic [3:0] {
		PH_IDLE,
		PH_ADDR,
		PH_ADDR_ACK,
		PH_CMD,
		PH_CMD_ACK,
		PH_WDATA,
		PH_WDATA_ACK,
		PH_RDATA,
		PH_RDATA_ACK
	} link_phase_t;

	// Register contents published to the link for readback.
	typedef struct packed {
		logic [PORT_W-1:0] input_port;
		logic [PORT_W-1:0] output_port;
		logic [PORT_W-1:0] polarity;
		logic [PORT_W-1:0] dir_cfg;
	} port_regs_t;

	// State kept on the link clock.
	typedef struct packed {
		link_phase_t phase;
		logic [2:0] bit_cnt;
		logic [PORT_W-1:0] shift;
		logic [PORT_W-1:0] tx;
		logic [SEL_W-1:0] sel;
		logic rw;
		logic selected;
		logic start_seen;
		logic stop_seen;
		logic wr_tgl;
		logic rd_tgl;
		logic [SEL_W-1:0] wr_sel;
		logic [PORT_W-1:0] wr_data;
	} link_t;

	// State kept on the system clock.
	typedef struct packed {
		logic link_rst;
		logic [PORT_W-1:0] out_port;
		logic [PORT_W-1:0] polarity;
		logic [PORT_W-1:0] dir_cfg;
		logic [PORT_W-1:0] pin_oe;
		logic [PORT_W-1:0] cap;
		port_regs_t regs;
		logic [ALERT_CNT_W-1:0] alert_cnt;
		logic alert_oe;
		logic alert_n_out;
		logic sda_out;
		logic wr_seen;
		logic rd_seen;
		logic stop_seen;
	} sys_t;

endpackage

// ### bit_sync.sv
// Two flip-flop level synchroniser of configurable width.
// Assumes each bit is an independent level or a toggle held long enough to be seen.
`timescale 1ns/1ns
module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_t;

	sync_t st;
	sync_t next_st;

	// The first stage feeds only the second stage.
	always_comb begin
		next_st.meta = i_d;
		next_st.stable = st.meta;
	end

	// Both stages register on every edge; no reset is needed for a pure delay.
	always_ff @(posedge i_clk) begin
		st <= next_st;
	end

	assign o_q = st.stable;

endmodule

// ### io_expander.sv
// Bus target and input change alert for an eight pin port expander.
// Assumes an open-drain bus resolved outside, and the bus clock as the link clock.
`timescale 1ns/1ns
module io_expander
	import io_expander_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic [PORT_W-1:0] i_expander_pins,
	input wire logic [STRAP_W-1:0] i_addr_strap_pins,
	output logic o_sda_out,
	output logic o_sda_oe,
	output logic [PORT_W-1:0] o_expander_pins_out,
	output logic [PORT_W-1:0] o_expander_pins_oe,
	output logic o_alert_n_out,
	output logic o_alert_oe
);

	// Picks the register addressed by a selection code.
	function automatic logic [PORT_W-1:0] sel_reg(input port_regs_t regs,
		input logic [SEL_W-1:0] sel);
		logic [PORT_W-1:0] val;
		unique case (sel)
			SEL_INPUT: val = regs.input_port;
			SEL_OUTPUT: val = regs.output_port;
			SEL_POLARITY: val = regs.polarity;
			SEL_CONFIG: val = regs.dir_cfg;
		endcase
		return val;
	endfunction

	sys_t sys;
	sys_t next_sys;
	link_t link;
	link_t next_link;
	logic start_tgl;
	logic stop_tgl;
	logic sda_oe;
	logic next_sda_oe;
	logic [PORT_W-1:0] pins_s;
	logic [3:0] tgl_s;
	logic [STRAP_W-1:0] strap_l;
	port_regs_t regs_l;
	logic [PORT_W-1:0] byte_in;
	logic [PORT_W-1:0] mismatch;
	logic wr_ev;
	logic rd_ev;
	logic stop_ev;
	logic clear;

	// Pins enter the system clock domain through two flops before any comparison.
	bit_sync #(.WIDTH(PORT_W)) u_pin_sync (
		.i_clk(i_mclk),
		.i_d(i_expander_pins),
		.o_q(pins_s)
	);

	// Link events arrive as toggles; the selected flag is a level.
	bit_sync #(.WIDTH(4)) u_tgl_sync (
		.i_clk(i_mclk),
		.i_d({link.selected, stop_tgl, link.rd_tgl, link.wr_tgl}),
		.o_q(tgl_s)
	);

	// Straps and published registers are static for many link edges before use.
	bit_sync #(.WIDTH(STRAP_W)) u_strap_sync (
		.i_clk(i_scl),
		.i_d(i_addr_strap_pins),
		.o_q(strap_l)
	);

	bit_sync #(.WIDTH($bits(port_regs_t))) u_regs_sync (
		.i_clk(i_scl),
		.i_d(sys.regs),
		.o_q(regs_l)
	);

	// Start and Stop are the only data edges while the clock is high, so the data
	// line itself clocks these two toggles; they settle half a bit before use.
	always_ff @(negedge i_sda or posedge sys.link_rst) begin
		if (sys.link_rst) begin
			start_tgl <= 1'b0;
		end else if (i_scl) begin
			start_tgl <= ~start_tgl;
		end
	end

	always_ff @(posedge i_sda or posedge sys.link_rst) begin
		if (sys.link_rst) begin
			stop_tgl <= 1'b0;
		end else if (i_scl) begin
			stop_tgl <= ~stop_tgl;
		end
	end

	// Receive side of the link: sample data on the rising clock edge.
	always_comb begin
		next_link = link;
		byte_in = {link.shift[PORT_W-2:0], i_sda};
		if (start_tgl != link.start_seen) begin
			// A start or repeated start drops the selection until our address is matched again.
			next_link.start_seen = start_tgl;
			next_link.stop_seen = stop_tgl;
			next_link.phase = PH_ADDR;
			next_link.shift = {{(PORT_W-1){1'b0}}, i_sda};
			next_link.bit_cnt = BIT_SECOND;
			next_link.selected = 1'b0;
		end else if (stop_tgl != link.stop_seen) begin
			next_link.stop_seen = stop_tgl;
			next_link.phase = PH_IDLE;
		end else begin
			unique case (link.phase)
				PH_IDLE: begin
				end
				PH_ADDR, PH_CMD, PH_WDATA: begin
					next_link.shift = byte_in;
					next_link.bit_cnt = 3'(link.bit_cnt + BIT_STEP);
					if (link.bit_cnt == BIT_LAST) begin
						next_link.bit_cnt = BIT_FIRST;
						if (link.phase == PH_ADDR) begin
							// Only our own address is answered; other targets leave us idle.
							if (byte_in[PORT_W-1:1] == {ADDR_FIXED, strap_l}) begin
								next_link.phase = PH_ADDR_ACK;
								next_link.rw = byte_in[RW_BIT];
								next_link.selected = 1'b1;
								next_link.tx = sel_reg(regs_l, link.sel);
							end else begin
								next_link.phase = PH_IDLE;
							end
						end else if (link.phase == PH_CMD) begin
							next_link.sel = byte_in[SEL_W-1:0];
							next_link.phase = PH_CMD_ACK;
						end else begin
							next_link.wr_data = byte_in;
							next_link.phase = PH_WDATA_ACK;
						end
					end
				end
				PH_ADDR_ACK: begin
					next_link.phase = link.rw ? PH_RDATA : PH_CMD;
				end
				PH_CMD_ACK: begin
					next_link.phase = PH_WDATA;
				end
				PH_WDATA_ACK: begin
					// The byte is handed over on the acknowledge rising edge, without limit.
					next_link.wr_tgl = ~link.wr_tgl;
					next_link.wr_sel = link.sel;
					next_link.phase = PH_WDATA;
				end
				PH_RDATA: begin
					next_link.tx = {link.tx[PORT_W-2:0], 1'b0};
					next_link.bit_cnt = 3'(link.bit_cnt + BIT_STEP);
					if (link.bit_cnt == BIT_LAST) begin
						next_link.bit_cnt = BIT_FIRST;
						next_link.phase = PH_RDATA_ACK;
					end
				end
				PH_RDATA_ACK: begin
					// Acknowledge or not, an input port read toggles the read event that clears the alert at this edge.
					if (link.sel == SEL_INPUT) begin
						next_link.rd_tgl = ~link.rd_tgl;
					end
					if (!i_sda) begin
						next_link.tx = sel_reg(regs_l, link.sel);
						next_link.phase = PH_RDATA;
					end else begin
						next_link.phase = PH_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_scl or posedge sys.link_rst) begin
		if (sys.link_rst) begin
			link <= '0;
		end else begin
			link <= next_link;
		end
	end

	// Transmit side: change the data line only while the clock is low.
	always_comb begin
		next_sda_oe = 1'b0;
		if (stop_tgl == link.stop_seen) begin
			unique case (link.phase)
				PH_ADDR_ACK, PH_CMD_ACK, PH_WDATA_ACK: next_sda_oe = 1'b1;
				PH_RDATA: next_sda_oe = ~link.tx[PORT_W-1];
				PH_IDLE, PH_ADDR, PH_CMD, PH_WDATA, PH_RDATA_ACK: next_sda_oe = 1'b0;
			endcase
		end
	end

	always_ff @(negedge i_scl or posedge sys.link_rst) begin
		if (sys.link_rst) begin
			sda_oe <= 1'b0;
		end else begin
			sda_oe <= next_sda_oe;
		end
	end

	assign o_sda_oe = sda_oe;

	// Events from the link, found by comparing synchronised toggles.
	assign wr_ev = tgl_s[0] != sys.wr_seen;
	assign rd_ev = tgl_s[1] != sys.rd_seen;
	assign stop_ev = tgl_s[2] != sys.stop_seen;
	assign clear = rd_ev || (stop_ev && tgl_s[3]);
	// Output-mode pins are masked out; a fresh input may differ from the capture.
	assign mismatch = (pins_s ^ sys.cap) & sys.dir_cfg;

	// System clock side: registers, alert timing and readback publication.
	always_comb begin
		next_sys = sys;
		next_sys.link_rst = 1'b0;
		next_sys.alert_n_out = 1'b0;
		next_sys.sda_out = 1'b0;
		next_sys.wr_seen = tgl_s[0];
		next_sys.rd_seen = tgl_s[1];
		next_sys.stop_seen = tgl_s[2];
		if (wr_ev) begin
			// Writes to the input port have no effect.
			unique case (link.wr_sel)
				SEL_INPUT: begin
				end
				SEL_OUTPUT: next_sys.out_port = link.wr_data;
				SEL_POLARITY: next_sys.polarity = link.wr_data;
				SEL_CONFIG: next_sys.dir_cfg = link.wr_data;
			endcase
		end
		if (clear) begin
			// A pin moving in this very cycle is captured too, so it may go unseen.
			next_sys.cap = pins_s;
		end
		if (clear || mismatch == '0) begin
			next_sys.alert_cnt = '0;
			next_sys.alert_oe = 1'b0;
		end else if (sys.alert_cnt != ALERT_VALID_CNT) begin
			next_sys.alert_cnt = 6'(sys.alert_cnt + ALERT_CNT_STEP);
		end else begin
			next_sys.alert_oe = 1'b1;
		end
		next_sys.pin_oe = ~next_sys.dir_cfg;
		next_sys.regs.input_port = pins_s ^ next_sys.polarity;
		next_sys.regs.output_port = next_sys.out_port;
		next_sys.regs.polarity = next_sys.polarity;
		next_sys.regs.dir_cfg = next_sys.dir_cfg;
		if (i_rst) begin
			next_sys = '0;
			next_sys.link_rst = 1'b1;
			next_sys.out_port = RST_OUTPUT;
			next_sys.polarity = RST_POLARITY;
			next_sys.dir_cfg = RST_CONFIG;
			next_sys.pin_oe = ~RST_CONFIG;
			next_sys.cap = pins_s;
			next_sys.wr_seen = tgl_s[0];
			next_sys.rd_seen = tgl_s[1];
			next_sys.stop_seen = tgl_s[2];
		end
	end

	always_ff @(posedge i_mclk) begin
		sys <= next_sys;
	end

	assign o_expander_pins_out = sys.out_port;
	assign o_expander_pins_oe = sys.pin_oe;
	assign o_alert_n_out = sys.alert_n_out;
	assign o_alert_oe = sys.alert_oe;
	assign o_sda_out = sys.sda_out;

	// Helper for the checks: cycles that a mismatch has stood without a clear.
	localparam int PERSIST_HIT = ALERT_VALID_CYCLES + 1;
	logic [7:0] persist;
	always_ff @(posedge i_mclk) begin
		if (i_rst || mismatch == '0 || clear) begin
			persist <= 8'h00;
		end else if (persist != 8'hff) begin
			persist <= 8'(persist + 8'h01);
		end
	end

	// The alert line is never driven high.
	property p_alert_open_drain;
		@(posedge i_mclk) disable iff (i_rst) o_alert_oe |-> o_alert_n_out == 1'b0;
	endproperty
	a_alert_open_drain: assert property (p_alert_open_drain) else $error("alert drives high");
	// The alert rises exactly after the valid delay of standing mismatch.
	property p_alert_rise_time;
		@(posedge i_mclk) disable iff (i_rst) $rose(o_alert_oe) |-> persist == PERSIST_HIT;
	endproperty
	a_alert_rise_time: assert property (p_alert_rise_time) else $error("alert rose off time");
	property p_alert_raised;
		@(posedge i_mclk) disable iff (i_rst) persist >= PERSIST_HIT |-> o_alert_oe;
	endproperty
	a_alert_raised: assert property (p_alert_raised) else $error("alert not raised");
	// No alert without an input-mode difference one cycle before.
	property p_output_pin_quiet;
		@(posedge i_mclk) disable iff (i_rst) $rose(o_alert_oe) |-> $past(mismatch) != '0;
	endproperty
	a_output_pin_quiet: assert property (p_output_pin_quiet) else $error("alert without cause");
	property p_read_clears;
		@(posedge i_mclk) disable iff (i_rst) rd_ev |=> !o_alert_oe ##1 sys.cap == $past(pins_s, 2);
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not clear");
	property p_return_clears;
		@(posedge i_mclk) disable iff (i_rst) mismatch == '0 |=> !o_alert_oe;
	endproperty
	a_return_clears: assert property (p_return_clears) else $error("alert held after return");
	// A Stop from a frame that was not ours leaves a standing alert alone.
	property p_foreign_stop;
		@(posedge i_mclk) disable iff (i_rst)
			stop_ev && !tgl_s[3] && !rd_ev && o_alert_oe && mismatch != '0 |=> o_alert_oe;
	endproperty
	a_foreign_stop: assert property (p_foreign_stop) else $error("foreign stop cleared");

	property p_write_config;
		@(posedge i_mclk) disable iff (i_rst)
			wr_ev && link.wr_sel == SEL_CONFIG |=> o_expander_pins_oe == ~$past(link.wr_data);
	endproperty
	a_write_config: assert property (p_write_config) else $error("direction not written");

	property p_input_read_only;
		@(posedge i_mclk) disable iff (i_rst)
			wr_ev && link.wr_sel == SEL_INPUT |=> $stable(o_expander_pins_out) && $stable(sys.dir_cfg);
	endproperty
	a_input_read_only: assert property (p_input_read_only) else $error("input port written");

	// A read address acknowledge leads into the first bit of the read byte.
	property p_read_selected;
		@(posedge i_scl) disable iff (sys.link_rst)
			link.phase == PH_ADDR_ACK && link.rw |=> link.phase == PH_RDATA ##0 link.bit_cnt == BIT_FIRST;
	endproperty
	a_read_selected: assert property (p_read_selected) else $error("read did not start");

	c_alert_rise: cover property (@(posedge i_mclk) disable iff (i_rst) $rose(o_alert_oe));
	c_read_clear: cover property (@(posedge i_mclk) disable iff (i_rst) rd_ev && o_alert_oe);
	c_cfg_write: cover property (@(posedge i_mclk) wr_ev && link.wr_sel == SEL_CONFIG);
	c_stop_clear: cover property (@(posedge i_mclk) disable iff (i_rst) stop_ev && tgl_s[3]);

endmodule

// ### i2c_ctrl_model.sv
// Bus controller model: drives the bus clock and pulls the data line low.
// Assumes the bench resolves the data line with a pull-up to high.
`timescale 1ns/1ns
module i2c_ctrl_model (
	output logic o_scl,
	output logic o_sda_oe,
	input wire logic i_sda
);
	// The clock stands high between frames, so the target sees no stray edges.
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	// Data changes in mid low phase and is sampled at the rising clock edge.
	task automatic put_bit(input logic b, output logic s);
		o_scl = 1'b0;
		#20 o_sda_oe = ~b;
		#20 o_scl = 1'b1;
		s = i_sda;
		#40;
	endtask
	// Start from idle, or a repeated start once the clock has run.
	task automatic start(input logic again);
		if (again) begin
			o_scl = 1'b0;
			#20 o_sda_oe = 1'b0;
			#20 o_scl = 1'b1;
			#40;
		end
		o_sda_oe = 1'b1;
		#40;
	endtask
	// Data rises while the clock is high; the clock then stands still.
	task automatic stop();
		o_scl = 1'b0;
		#20 o_sda_oe = 1'b1;
		#20 o_scl = 1'b1;
		#40 o_sda_oe = 1'b0;
		#40;
	endtask
	// Eight bits out, most significant first, then the target's acknowledge.
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], s);
		end
		put_bit(1'b1, ack);
		ack = ~ack;
	endtask
	// Eight bits in; the final byte of a read is left without acknowledge.
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, s);
			d[i] = s;
		end
		put_bit(~ack, s);
	endtask
endmodule

// ### tb.sv
// Self-checking bench for the port expander: bus frames, registers and change alert.
// Assumes the controller model and pull-ups on the data and alert lines.
`timescale 1ns/1ns
module tb;
	import io_expander_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [PORT_W-1:0] pin_drv = 8'h00;
	logic [STRAP_W-1:0] strap = 3'h0;
	logic scl, ctrl_oe, sda_out, sda_oe, alert_n_out, alert_oe;
	logic [PORT_W-1:0] pins, pins_out, pins_oe;
	logic [7:0] regs [4];
	logic [6:0] me;
	logic [7:0] d0, d1;
	logic [1:0] b;
	logic ack, mid;
	int n_mismatch = 0;
	int cmp_count = 0;
	// Open-drain lines: low when any party pulls, else the pull-up wins.
	wire logic sda = (ctrl_oe | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
	wire logic alert_line = (alert_oe & ~alert_n_out) ? 1'b0 : 1'b1;
	assign pins = (pins_oe & pins_out) | (~pins_oe & pin_drv);
	always #50 i_mclk = ~i_mclk;
	io_expander i_io_expander (.i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
		.i_expander_pins(pins), .i_addr_strap_pins(strap), .o_sda_out(sda_out),
		.o_sda_oe(sda_oe), .o_expander_pins_out(pins_out), .o_expander_pins_oe(pins_oe),
		.o_alert_n_out(alert_n_out), .o_alert_oe(alert_oe));
	i2c_ctrl_model i_i2c_ctrl_model (.o_scl(scl), .o_sda_oe(ctrl_oe), .i_sda(sda));
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Inputs move a fixed 5 ns after the rising edge, never on it.
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#5;
	endtask
	task automatic alert_is(input logic exp);
		check(8'(alert_oe), 8'(exp));
		check(8'(alert_line), 8'(!exp));
	endtask
	// Input port as the rules give it: output pins show the output register, inputs the bench.
	function automatic logic [7:0] exp_in();
		return ((regs[1] & ~regs[3]) | (pin_drv & regs[3])) ^ regs[2];
	endfunction
	// One write frame: address, command, then n data bytes, low byte first.
	task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input logic [15:0] d,
		input int n);
		i_i2c_ctrl_model.start(1'b0);
		i_i2c_ctrl_model.wbyte({a, 1'b0}, ack);
		check(8'(ack), 8'(a == me));
		if (ack) begin
			i_i2c_ctrl_model.wbyte(cmd, ack);
			for (int i = 0; i < n; i++) begin
				i_i2c_ctrl_model.wbyte(d[8*i +: 8], ack);
				check(8'(ack), 8'h01);
			end
		end
		i_i2c_ctrl_model.stop();
		tick(8);
	endtask
	// Two-byte read; the alert is sampled after the first acknowledge.
	task automatic rd(input logic [7:0] cmd, input logic with_cmd);
		i_i2c_ctrl_model.start(1'b0);
		if (with_cmd) begin
			i_i2c_ctrl_model.wbyte({me, 1'b0}, ack);
			i_i2c_ctrl_model.wbyte(cmd, ack);
			i_i2c_ctrl_model.start(1'b1);
		end
		i_i2c_ctrl_model.wbyte({me, 1'b1}, ack);
		check(8'(ack), 8'h01);
		i_i2c_ctrl_model.rbyte(1'b1, d0);
		tick(10);
		mid = alert_oe;
		i_i2c_ctrl_model.rbyte(1'b0, d1);
		i_i2c_ctrl_model.stop();
		tick(8);
	endtask
	// A hang costs a mismatch; the span is well above the expected run.
	initial begin
		#3000000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		void'($urandom(32'hba439563));
		strap = 3'($urandom);
		tick(12);
		i_rst = 1'b0;
		tick(3);
		me = {ADDR_FIXED, strap};
		check(pins_out, RST_OUTPUT);
		check(pins_oe, ~RST_CONFIG);
		alert_is(1'b0);
		// Random data into each writable register; upper command bits are noise.
		regs[0] = 8'h00;
		for (int s = 1; s < 4; s++) begin
			d0 = 8'($urandom);
			d1 = 8'($urandom);
			regs[s] = d1;
			wr(me, {6'($urandom), 2'(s)}, {d1, d0}, 2);
		end
		tick(10);
		check(pins_out, regs[1]);
		check(pins_oe, ~regs[3]);
		for (int s = 1; s < 4; s++) begin
			rd(8'(s), 1'b1);
			check(d0, regs[s]);
			check(d1, regs[s]);
		end
		rd(8'h00, 1'b0);
		check(d0, regs[3]);
		// Data written to the input port must leave every other register untouched.
		wr(me, 8'h00, 16'h5a5a, 2);
		check(pins_oe, ~regs[3]);
		// Frames to other targets: one wrong strap, one wrong fixed pattern.
		wr(me ^ 7'h01, 8'h01, 16'h0000, 1);
		wr(me ^ 7'h40, 8'h01, 16'h0000, 1);
		check(pins_out, regs[1]);
		// A Stop inside the command byte ends the frame and frees the data line.
		i_i2c_ctrl_model.start(1'b0);
		i_i2c_ctrl_model.wbyte({me, 1'b0}, ack);
		repeat (3) i_i2c_ctrl_model.put_bit(1'b0, ack);
		i_i2c_ctrl_model.stop();
		check(8'(sda_oe), 8'h00);
		// Low nibble inputs; a read then settles any alert from the turnaround.
		regs[3] = 8'h0f;
		wr(me, 8'h03, 16'h000f, 1);
		rd(8'h00, 1'b1);
		check(d0, exp_in());
		tick(60);
		alert_is(1'b0);
		// Each round raises the alert, then clears it by return, read or Stop.
		for (int r = 0; r < 3; r++) begin
			b = 2'($urandom);
			pin_drv[b] = ~pin_drv[b];
			tick(30);
			alert_is(1'b0);
			tick(20);
			alert_is(1'b1);
			if (r == 0) begin
				pin_drv[b] = ~pin_drv[b];
			end else if (r == 1) begin
				wr(me ^ 7'h02, 8'h00, 16'h0000, 0);
				alert_is(1'b1);
				rd(8'h00, 1'b1);
				check(8'(mid), 8'h00);
				check(d0, exp_in());
			end else begin
				wr(me, 8'h02, {8'h00, regs[2]}, 1);
			end
			tick(50);
			alert_is(1'b0);
		end
		// Output pins follow the register but never raise the alert.
		regs[1] = ~regs[1];
		wr(me, 8'h01, {8'h00, regs[1]}, 1);
		pin_drv[7:4] = ~pin_drv[7:4];
		tick(60);
		check(pins_out, regs[1]);
		alert_is(1'b0);
		finish_test();
	end
endmodule
